// ---- core/ppu_top.sv ----
// Top of the pulse pattern output path: APB registers and output latches.
// Assumes timer trigger pulses are one sys_clk cycle wide, same domain.
//
// Our own choices: the register offsets and the APB register port.
`default_nettype none
module ppu_top
  import ppu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PPU_TRIG_N-1:0] timer_trig,
  output logic [PPU_BITS-1:0] pulse_pins
);
  logic [PPU_HALF-1:0] next_enable_high_r;
  logic [PPU_HALF-1:0] next_enable_low_r;
  logic [PPU_HALF-1:0] staged_data_high_r;
  logic [PPU_HALF-1:0] staged_data_low_r;
  logic [PPU_SEL_REG_W-1:0] trigger_select_reg_r;
  logic [PPU_BITS-1:0] output_latch_bits_r;
  logic [PPU_BITS-1:0] next_enable_bits;
  logic [PPU_BITS-1:0] staged_data_bits;
  logic [PPU_BITS-1:0] latch_nxt;
  logic [PPU_BITS-1:0] bit_fire;
  logic [PPU_BITS-1:0] take_bits;
  logic [PPU_BITS-1:0] kept_bits;
  logic [PPU_HALF-1:0] wr_byte;
  logic [31:0] rd_nxt;
  logic [31:0] rd_en_h;
  logic [31:0] rd_en_l;
  logic [31:0] rd_lat_h;
  logic [31:0] rd_lat_l;
  logic [31:0] rd_stg_h;
  logic [31:0] rd_stg_l;
  logic [31:0] rd_trig;
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic rd_acc;
  logic lane0;
  logic sel_en_h;
  logic sel_en_l;
  logic sel_lat_h;
  logic sel_lat_l;
  logic sel_stg_h;
  logic sel_stg_l;
  logic sel_trig;
  logic wr_en_h;
  logic wr_en_l;
  logic wr_lat_h;
  logic wr_lat_l;
  logic wr_stg_h;
  logic wr_stg_l;
  logic wr_trig;
  logic hit;
  logic err_nxt;
  logic ready_nxt;

  ppu_trig_if tif();
  assign tif.sel = trigger_select_reg_r;
  assign tif.src = timer_trig;

  ppu_trig_mux u_mux (
    .tif(tif)
  );

  // Register offset compare, shared by the write strobes and the read mux.
  function automatic logic addr_is(
    input logic [11:0] a,
    input logic [11:0] ofs
  );
    return a == ofs;
  endfunction

  // One register byte placed in the low lane of an otherwise zero word.
  function automatic logic [31:0] byte_word(
    input logic [PPU_HALF-1:0] b
  );
    logic [31:0] w;
    w = PPU_RD_ZERO;
    w[PPU_HALF-1:0] = b;
    return w;
  endfunction

  // Software write byte for a half, masked so enabled bits stay put.
  function automatic logic [PPU_HALF-1:0] sw_merge(
    input logic [PPU_HALF-1:0] cur,
    input logic [PPU_HALF-1:0] en,
    input logic [PPU_HALF-1:0] wd
  );
    return (cur & en) | (wd & ~en);
  endfunction

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  // A write lands only at the edge where the master sees pready high.
  assign wr_acc = access_ph & pwrite & pready;
  // Read data is loaded at the end of setup and stands through access.
  assign rd_acc = setup_ph & ~pwrite;
  assign lane0 = pstrb[0];
  assign wr_byte = pwdata[PPU_HALF-1:0];

  assign sel_en_h = addr_is(paddr, PPU_OFS_NEXT_EN_H);
  assign sel_en_l = addr_is(paddr, PPU_OFS_NEXT_EN_L);
  assign sel_lat_h = addr_is(paddr, PPU_OFS_LATCH_H);
  assign sel_lat_l = addr_is(paddr, PPU_OFS_LATCH_L);
  assign sel_stg_h = addr_is(paddr, PPU_OFS_STAGED_H);
  assign sel_stg_l = addr_is(paddr, PPU_OFS_STAGED_L);
  assign sel_trig = addr_is(paddr, PPU_OFS_TRIG_SEL);
  assign hit = sel_en_h | sel_en_l | sel_lat_h | sel_lat_l
    | sel_stg_h | sel_stg_l | sel_trig;
  assign err_nxt = setup_ph & ~hit;
  // Zero wait states: every setup is answered in the cycle after it.
  assign ready_nxt = setup_ph;

  // Unmapped or strobe-less writes match no strobe and change nothing.
  assign wr_en_h = wr_acc & lane0 & sel_en_h;
  assign wr_en_l = wr_acc & lane0 & sel_en_l;
  assign wr_lat_h = wr_acc & lane0 & sel_lat_h;
  assign wr_lat_l = wr_acc & lane0 & sel_lat_l;
  assign wr_stg_h = wr_acc & lane0 & sel_stg_h;
  assign wr_stg_l = wr_acc & lane0 & sel_stg_l;
  assign wr_trig = wr_acc & lane0 & sel_trig;

  assign next_enable_bits = {next_enable_high_r, next_enable_low_r};
  assign staged_data_bits = {staged_data_high_r, staged_data_low_r};

  genvar g;
  generate
    for (g = 0; g < PPU_GROUPS; g++) begin : gfire
      assign bit_fire[g*PPU_GBITS +: PPU_GBITS] = {PPU_GBITS{tif.fire[g]}};
    end
  endgenerate

  assign kept_bits[PPU_BITS-1:PPU_HALF] = wr_lat_h
    ? sw_merge(output_latch_bits_r[PPU_BITS-1:PPU_HALF],
      next_enable_bits[PPU_BITS-1:PPU_HALF], wr_byte)
    : output_latch_bits_r[PPU_BITS-1:PPU_HALF];
  assign kept_bits[PPU_HALF-1:0] = wr_lat_l
    ? sw_merge(output_latch_bits_r[PPU_HALF-1:0],
      next_enable_bits[PPU_HALF-1:0], wr_byte)
    : output_latch_bits_r[PPU_HALF-1:0];

  // A trigger and a software write in one cycle never meet on a bit:
  // the write only reaches disabled bits, the trigger only enabled ones.
  genvar i;
  generate
    for (i = 0; i < PPU_BITS; i++) begin : gbit
      assign take_bits[i] = bit_fire[i] & next_enable_bits[i];
      assign latch_nxt[i] = take_bits[i] ? staged_data_bits[i]
        : kept_bits[i];
    end
  endgenerate

  assign rd_en_h = byte_word(next_enable_high_r);
  assign rd_en_l = byte_word(next_enable_low_r);
  assign rd_lat_h = byte_word(output_latch_bits_r[PPU_BITS-1:PPU_HALF]);
  assign rd_lat_l = byte_word(output_latch_bits_r[PPU_HALF-1:0]);
  assign rd_stg_h = byte_word(staged_data_high_r);
  assign rd_stg_l = byte_word(staged_data_low_r);
  assign rd_trig = byte_word(trigger_select_reg_r);

  always_comb begin
    rd_nxt = PPU_RD_ZERO;
    if (sel_en_h) begin
      rd_nxt = rd_en_h;
    end else if (sel_en_l) begin
      rd_nxt = rd_en_l;
    end else if (sel_lat_h) begin
      rd_nxt = rd_lat_h;
    end else if (sel_lat_l) begin
      rd_nxt = rd_lat_l;
    end else if (sel_stg_h) begin
      rd_nxt = rd_stg_h;
    end else if (sel_stg_l) begin
      rd_nxt = rd_stg_l;
    end else if (sel_trig) begin
      rd_nxt = rd_trig;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= ready_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= err_nxt;
    end
  end

  // Read data holds between reads so the master may sample it late.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= PPU_RD_ZERO;
    end else if (rd_acc) begin
      prdata <= rd_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      next_enable_high_r <= PPU_RST_BYTE;
    end else if (wr_en_h) begin
      next_enable_high_r <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      next_enable_low_r <= PPU_RST_BYTE;
    end else if (wr_en_l) begin
      next_enable_low_r <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      staged_data_high_r <= PPU_RST_BYTE;
    end else if (wr_stg_h) begin
      staged_data_high_r <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      staged_data_low_r <= PPU_RST_BYTE;
    end else if (wr_stg_l) begin
      staged_data_low_r <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trigger_select_reg_r <= PPU_RST_BYTE;
    end else if (wr_trig) begin
      trigger_select_reg_r <= wr_byte[PPU_SEL_REG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      output_latch_bits_r <= {PPU_RST_BYTE, PPU_RST_BYTE};
    end else begin
      output_latch_bits_r <= latch_nxt;
    end
  end

  // pins follow latch
  // The pins take the same next value as the latch, so they never lag it.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_pins <= {PPU_RST_BYTE, PPU_RST_BYTE};
    end else begin
      pulse_pins <= latch_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- core/ppu_trig_mux.sv ----
// Per-group trigger selection for the pulse pattern output path.
// Assumes trigger sources are single-cycle pulses on sys_clk.
`default_nettype none
module ppu_trig_mux
  import ppu_pkg::*;
(
  ppu_trig_if.mux tif
);
  genvar g;
  generate
    for (g = 0; g < PPU_GROUPS; g++) begin : gsel
      assign tif.fire[g] = tif.src[tif.sel[g*PPU_SEL_W +: PPU_SEL_W]];
    end
  endgenerate
endmodule
`default_nettype wire

// ---- inc/ppu_pkg.sv ----
// Constants, register map and types of the pulse pattern output path.
// Assumes a 32-bit APB master and a timer time base giving trigger pulses.
//
// Behaviour
// - Sixteen pulse output bits form four 4-bit groups, group 3 on top.
// - All groups run at once, each with its own independent trigger.
// - Output triggers come from the companion 16-bit timer time base.
// - On its trigger an enabled bit copies its staged bit to its latch.
// - On a trigger a disabled bit keeps its output latch unchanged.
// - Software writes to an enabled output latch bit are ignored.
// - Software writes to a disabled output latch bit are accepted.
// - Each 16-bit control set is split into high (15:8) and low (7:0).
// - Staged next data sits in separate high and low staged registers.
// - Each group selects its own trigger source in a control register.
`default_nettype none
package ppu_pkg;
  localparam int PPU_GROUPS = 4;
  localparam int PPU_GBITS = 4;
  localparam int PPU_BITS = PPU_GROUPS * PPU_GBITS;
  localparam int PPU_HALF = 8;
  localparam int PPU_TRIG_N = 4;
  localparam int PPU_SEL_W = 2;
  localparam int PPU_SEL_REG_W = PPU_GROUPS * PPU_SEL_W;
  localparam logic [11:0] PPU_OFS_NEXT_EN_H = 12'h000;
  localparam logic [11:0] PPU_OFS_NEXT_EN_L = 12'h004;
  localparam logic [11:0] PPU_OFS_LATCH_H = 12'h008;
  localparam logic [11:0] PPU_OFS_LATCH_L = 12'h00c;
  localparam logic [11:0] PPU_OFS_STAGED_H = 12'h010;
  localparam logic [11:0] PPU_OFS_STAGED_L = 12'h014;
  localparam logic [11:0] PPU_OFS_TRIG_SEL = 12'h018;
  localparam logic [7:0] PPU_RST_BYTE = 8'h00;
  localparam logic [31:0] PPU_RD_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- inc/ppu_trig_if.sv ----
// Carries the trigger select field and the per-group trigger pulses.
// Assumes trigger inputs are already on the sys_clk domain.
`default_nettype none
interface ppu_trig_if;
  import ppu_pkg::*;
  logic [PPU_SEL_REG_W-1:0] sel;
  logic [PPU_TRIG_N-1:0] src;
  logic [PPU_GROUPS-1:0] fire;
  modport ctrl (output sel, output src, input fire);
  modport mux (input sel, input src, output fire);
endinterface
`default_nettype wire

// ---- sim/ppu_load_model.sv ----
// External loads on the sixteen pulse pins.
// Assumes the pins are driven steadily and need no handshake.
`default_nettype none
module ppu_load_model (
  input wire logic [15:0] pins,
  output logic [15:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  assign level = pins;
endmodule
`default_nettype wire

// ---- sim/ppu_top_asserts.sv ----
// Port-level checks of the pulse pattern output path.
// Assumes it is bound to ppu_top.
`default_nettype none
module ppu_top_asserts
  import ppu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PPU_TRIG_N-1:0] timer_trig,
  input wire logic [PPU_BITS-1:0] pulse_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("late ready");
  a_ready_once: assert property (pready |=> !pready)
    else $error("long ready");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("stray ready");
  a_rd_upper: assert property (pready && !pwrite |-> !(|prdata[31:8]))
    else $error("upper bits set");
  a_err_map: assert property (pready |-> pslverr
    == ((paddr > PPU_OFS_TRIG_SEL) || (paddr[1:0] != 2'b00)))
    else $error("bad error");
  a_err_only: assert property (pslverr |-> pready)
    else $error("error alone");
  a_rd_hold: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata))
    else $error("read data moved");
  a_pins_idle: assert property (timer_trig == 0
    && !(psel && penable && pwrite) |=> $stable(pulse_pins))
    else $error("pins moved");
endmodule
bind ppu_top ppu_top_asserts CHK (.sys_clk(sys_clk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_trig(timer_trig), .pulse_pins(pulse_pins));
`default_nettype wire

// ---- sim/pulse_pattern_output_path_tb.sv ----
// Self-checking bench of the pulse pattern output path.
// Assumes ppu_top with an APB slave and four trigger inputs.
`default_nettype none
module pulse_pattern_output_path_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ppu_pkg::*;
  logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, s = 31;
  logic [3:0] timer_trig = 0, t;
  logic [15:0] pins, seen, en, stg, lat, ex;
  int miscompares = 0, tests_run = 0;
  ppu_top DUT (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_trig(timer_trig), .pulse_pins(pins));
  ppu_load_model LOAD (.pins(pins), .level(seen));
  initial forever #5 sys_clk = ~sys_clk;
  function automatic logic [15:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s[15:0];
  endfunction
  // Group g is wired to trigger g by the select value used below.
  function automatic logic [15:0] fire(input logic [3:0] q);
    logic [15:0] m;
    m = {{4{q[3]}}, {4{q[2]}}, {4{q[1]}}, {4{q[0]}}} & en;
    return (ex & ~m) | (stg & m);
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t mismatch", $time);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task results();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1;
    for (int a = 0; a < 8; a++) begin
      apb(0, 12'(a * 4), 8'h00);
      chk(r, 32'h0);
      chk({31'h0, er}, {31'h0, a == 7});
    end
    apb(1, PPU_OFS_TRIG_SEL, 8'he4);
    ex = 0;
    for (int i = 0; i < 12; i++) begin
      en = rnd();
      stg = rnd();
      lat = rnd();
      apb(1, PPU_OFS_NEXT_EN_H, en[15:8]);
      apb(1, PPU_OFS_NEXT_EN_L, en[7:0]);
      apb(1, PPU_OFS_STAGED_H, stg[15:8]);
      apb(1, PPU_OFS_STAGED_L, stg[7:0]);
      apb(1, PPU_OFS_LATCH_H, lat[15:8]);
      apb(1, PPU_OFS_LATCH_L, lat[7:0]);
      ex = (lat & ~en) | (ex & en);
      apb(0, PPU_OFS_LATCH_H, 8'h00);
      chk(r, {24'h0, ex[15:8]});
      apb(0, PPU_OFS_LATCH_L, 8'h00);
      chk(r, {24'h0, ex[7:0]});
      chk({16'h0, seen}, {16'h0, ex});
      t = (i == 0) ? 4'hf : 4'(rnd());
      @(posedge sys_clk) timer_trig <= t;
      @(posedge sys_clk) timer_trig <= 0;
      @(posedge sys_clk);
      ex = fire(t);
      chk({16'h0, seen}, {16'h0, ex});
    end
    results();
  end
endmodule
`default_nettype wire
